// ===== sample_formatter_regs.vh
// register map, field positions and timing counts for the sample packet
// formatter; definitions only, included by the formatter module alone
`ifndef SAMPLE_FORMATTER_REGS_VH
`define SAMPLE_FORMATTER_REGS_VH

// wishbone word offsets (byte addresses)
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_CTRL_WR     4'h8
`define REG_WORD        4'hc

// control register fields
`define CTRL_RUN        0
`define CTRL_EXT_SYNC   1
`define CTRL_TRIG_FALL  2
`define CTRL_TEST_EN    3
`define CTRL_TEST_LO    4
`define CTRL_TEST_HI    6
`define CTRL_RESET      8
`define CTRL_RST_VAL    9'h000

// packet word fields
`define PKT_FLAG        24
`define PKT_CTRL_HI     23
`define PKT_CTRL_LO     16
`define CB_COUNT_HI     7
`define CB_COUNT_LO     6
`define CB_MODE_HI      5
`define CB_MODE_LO      4
`define CB_CODE_HI      3
`define CB_CODE_LO      0

// switch modes
`define MODE_DIFF16     2'h0
`define MODE_ZERO       2'h1
`define MODE_SE_LOW     2'h2
`define MODE_SE_HIGH    2'h3

// timing: conversion time and internal trigger period
`define CLK_HZ          10000000
`define CONV_NS         2000
`define CONV_CYCLES     ((`CONV_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define INT_PERIOD      8'h19

`endif

// ===== sample_fifo.v
// small synchronous fifo of flip-flops with valid/ready on both sides
// assumes one clock, synchronous active-high reset, clock enable
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  // fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire do_wr = in_valid_i & in_ready_o;
  wire do_rd = out_valid_o & out_ready_i;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];

  always @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else if (ce_i) begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

  // storage carries no reset: contents are only read behind count
  always @(posedge clk_i) begin
    if (ce_i && do_wr) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

// ===== pin_sync.v
// two-flop synchroniser for a level arriving from a pin
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  // clock and reset
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  // pin and synchronised level
  input  wire pin_i,
  output reg  level_o
);

  reg meta;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta    <= 1'b0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      meta    <= pin_i;
      level_o <= meta;
    end
  end

endmodule

`default_nettype wire

// ===== sample_packet_formatter.v
// sample packet formatter: control byte fifo, conversion trigger,
// channel switch selection, test current steering, packet word output
// assumes a wishbone classic master on clk_i and an adc on the same clock
// assumes both external pins are asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
`include "sample_formatter_regs.vh"

module sample_packet_formatter (
  // clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // wishbone classic slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // external pins
  input  wire        ext_sample_trigger_i,
  input  wire        ext_acq_start_i,
  // adc
  output reg         adc_start_o,
  input  wire        adc_done_i,
  input  wire [13:0] adc_data_i,
  // analog switch and test current
  output reg  [4:0]  sel_channel_o,
  output reg         sel_diff_o,
  output reg         sel_zero_o,
  output reg  [31:0] test_current_o,
  output reg  [2:0]  test_config_o,
  // packet words toward the crate controller
  output reg  [24:0] pkt_word_o,
  output reg         pkt_valid_o,
  output reg         pkt_start_o
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_SEND = 2'h2;

  reg  [8:0]  ctrl;
  reg  [2:0]  test_cmd;
  reg         test_active;
  reg  [1:0]  rolling_count;
  reg  [7:0]  cur_byte;
  reg         cur_valid;
  reg  [1:0]  state;
  reg  [7:0]  conv_cnt;
  reg  [7:0]  int_cnt;
  reg         trig_prev;
  reg         running;
  reg  [15:0] overrun_cnt;
  reg  [24:0] last_word;

  wire        trig_lvl;
  wire        start_lvl;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [7:0]  fifo_out_data;

  wire        bus_req = cyc_i & stb_i & ~ack_o;
  wire        bus_wr  = bus_req & we_i & sel_i[0];
  wire        push    = bus_wr & (adr_i == `REG_CTRL_WR) & fifo_in_ready;
  wire        ext_sync = ctrl[`CTRL_EXT_SYNC];

  // edge chosen by software; the raw pin is never looked at here
  wire ext_edge = ctrl[`CTRL_TRIG_FALL] ? (trig_prev & ~trig_lvl)
                                        : (~trig_prev & trig_lvl);
  // a tick or edge that finds the block busy is lost, not queued
  wire int_tick = (int_cnt == `INT_PERIOD);
  wire trigger  = running & cur_valid & (state == ST_IDLE) &
                  (ext_sync ? ext_edge : int_tick);
  wire pop      = trigger | (~cur_valid & fifo_out_valid);

  // both pins pass two flops before any logic looks at them
  pin_sync trig_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .pin_i   (ext_sample_trigger_i),
    .level_o (trig_lvl)
  );

  pin_sync start_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .pin_i   (ext_acq_start_i),
    .level_o (start_lvl)
  );

  // a full fifo refuses the write; software sees it in the status word
  // the reset pulse empties it too, so no stale byte reaches a packet
  sample_fifo #(
    .WIDTH (8),
    .DEPTH (16),
    .AW    (4)
  ) ctrl_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i | ctrl[`CTRL_RESET]),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (dat_i[7:0]),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out_data)
  );

  // register file
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl        <= `CTRL_RST_VAL;
      test_cmd    <= 3'h0;
      test_active <= 1'b0;
      ack_o       <= 1'b0;
      dat_o       <= 32'h0000_0000;
    end else if (ce_i) begin
      // one wait state: ack follows the edge that takes the request
      ack_o <= bus_req;
      ctrl[`CTRL_RESET] <= 1'b0;
      if (bus_wr && adr_i == `REG_CTRL) begin
        ctrl <= dat_i[8:0];
        test_cmd    <= dat_i[`CTRL_TEST_HI:`CTRL_TEST_LO];
        test_active <= dat_i[`CTRL_TEST_EN];
      end
      // reads are registered, so dat_o stands until the next read
      if (bus_req && !we_i) begin
        case (adr_i)
          `REG_CTRL:   dat_o <= {23'h000000, ctrl};
          `REG_STATUS: dat_o <= {overrun_cnt, 8'h00, running,
                                 fifo_out_valid, ~fifo_in_ready,
                                 cur_valid, rolling_count, state};
          `REG_WORD:   dat_o <= {7'h00, last_word};
          default:     dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // internal trigger timer; it free-runs only while a run is active
  always @(posedge clk_i) begin
    if (rst_i) begin
      int_cnt <= 8'h00;
    end else if (ce_i) begin
      if (int_tick | ~running) begin
        int_cnt <= 8'h00;
      end else begin
        int_cnt <= int_cnt + 8'h01;
      end
    end
  end

  // run control, trigger timing and the packet sequence
  always @(posedge clk_i) begin
    if (rst_i) begin
      rolling_count <= 2'h0;
      cur_byte      <= 8'h00;
      cur_valid     <= 1'b0;
      state         <= ST_IDLE;
      conv_cnt      <= 8'h00;
      trig_prev     <= 1'b0;
      running       <= 1'b0;
      overrun_cnt   <= 16'h0000;
      last_word     <= 25'h0000000;
      adc_start_o   <= 1'b0;
      pkt_word_o    <= 25'h0000000;
      pkt_valid_o   <= 1'b0;
      pkt_start_o   <= 1'b0;
    end else if (ce_i) begin
      trig_prev   <= trig_lvl;
      adc_start_o <= 1'b0;
      pkt_valid_o <= 1'b0;
      pkt_start_o <= 1'b0;
      if (ctrl[`CTRL_RESET]) begin
        rolling_count <= 2'h0;
        cur_valid     <= 1'b0;
        running       <= 1'b0;
        state         <= ST_IDLE;
      end else begin
        if (ctrl[`CTRL_RUN] & (start_lvl | ~ext_sync)) begin
          running <= 1'b1;
        end else if (!ctrl[`CTRL_RUN]) begin
          running <= 1'b0;
        end
        if (pop) begin
          cur_valid <= fifo_out_valid;
          // an empty fifo keeps the last byte rather than a stale slot
          if (fifo_out_valid) begin
            cur_byte <= fifo_out_data;
          end
        end
        // saturates, so a flood of early edges never wraps back to zero
        if (ext_sync && ext_edge && state != ST_IDLE &&
            overrun_cnt != 16'hffff) begin
          overrun_cnt <= overrun_cnt + 16'h0001;
        end
        // one packet at a time; a trigger is taken only while the block is idle, else lost
        case (state)
          ST_IDLE: begin
            if (trigger) begin
              adc_start_o <= 1'b1;
              pkt_start_o <= 1'b1;
              conv_cnt    <= 8'h00;
              pkt_word_o[`PKT_CTRL_HI:`PKT_CTRL_LO] <=
                {rolling_count, cur_byte[`CB_MODE_HI:`CB_CODE_LO]};
              pkt_word_o[`PKT_FLAG] <= 1'b0;
              // the old sample never sits beside a new control byte
              pkt_word_o[15:0] <= 16'h0000;
              state <= ST_CONV;
            end
          end
          ST_CONV: begin
            // the adc done flag is trusted only after the minimum time
            if (conv_cnt < `CONV_CYCLES) begin
              conv_cnt <= conv_cnt + 8'h01;
            end else if (adc_done_i) begin
              state <= ST_SEND;
            end
          end
          ST_SEND: begin
            pkt_word_o[15:0] <= {{2{adc_data_i[13]}}, adc_data_i};
            last_word   <= {pkt_word_o[24:16],
                            {2{adc_data_i[13]}}, adc_data_i};
            pkt_valid_o   <= 1'b1;
            rolling_count <= rolling_count + 2'h1;
            state         <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // channel switch and test current steering from the active control byte
  always @(posedge clk_i) begin
    if (rst_i) begin
      sel_channel_o  <= 5'h00;
      sel_diff_o     <= 1'b0;
      sel_zero_o     <= 1'b0;
      test_current_o <= 32'h0000_0000;
      test_config_o  <= 3'h0;
    end else if (ce_i) begin
      // the switch already shows the next byte while the adc converts
      sel_zero_o <= 1'b0;
      sel_diff_o <= 1'b0;
      case (cur_byte[`CB_MODE_HI:`CB_MODE_LO])
        `MODE_DIFF16: begin
          sel_diff_o    <= 1'b1;
          sel_channel_o <= {1'b0, cur_byte[`CB_CODE_HI:`CB_CODE_LO]};
        end
        `MODE_ZERO: begin
          sel_zero_o    <= 1'b1;
          sel_channel_o <= 5'h00;
        end
        `MODE_SE_LOW: begin
          sel_channel_o <= {1'b0, cur_byte[`CB_CODE_HI:`CB_CODE_LO]};
        end
        default: begin
          sel_channel_o <= {1'b1, cur_byte[`CB_CODE_HI:`CB_CODE_LO]};
        end
      endcase
      // config bit 2 tells single-ended, bits 1:0 the circuit
      test_config_o <= {cur_byte[`CB_MODE_HI], test_cmd[1:0]};
      // zero-point mode has no input line, so no current is steered
      if (test_active && cur_valid &&
          cur_byte[`CB_MODE_HI:`CB_MODE_LO] != `MODE_ZERO) begin
        test_current_o <= 32'h0000_0001 <<
          {cur_byte[`CB_MODE_LO] & cur_byte[`CB_MODE_HI],
           cur_byte[`CB_CODE_HI:`CB_CODE_LO]};
      end else begin
        test_current_o <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

// ===== sample_packet_formatter_props.sv
// checker for the sample packet formatter, top ports only
// assumes one clock and a bind onto sample_packet_formatter
`timescale 1ns/1ps
`default_nettype none
module sample_packet_formatter_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [3:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // conversion and packets
  input wire logic        adc_start_o,
  input wire logic [4:0]  sel_channel_o,
  input wire logic        sel_diff_o,
  input wire logic        sel_zero_o,
  input wire logic [31:0] test_current_o,
  input wire logic [24:0] pkt_word_o,
  input wire logic        pkt_valid_o,
  input wire logic        pkt_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] cnt;
  wire  [1:0] md = pkt_word_o[21:20];
  wire        swr = cyc_i && stb_i && ack_o && we_i && adr_i == 4'h0
                    && sel_i[0] && dat_i[8];
  // shadow count; assumes no software reset while a packet is in flight
  always_ff @(posedge clk_i) begin
    if (rst_i || swr) cnt <= 2'h0;
    else if (pkt_valid_o) cnt <= cnt + 2'h1;
  end
  property p_flag;
    pkt_valid_o |-> !pkt_word_o[24];
  endproperty
  a_flag: assert property (p_flag) else $error("flag bit set");
  property p_sext;
    pkt_valid_o |-> pkt_word_o[15:14] == {2{pkt_word_o[13]}};
  endproperty
  a_sext: assert property (p_sext) else $error("bad sign extension");
  property p_count;
    pkt_start_o |-> pkt_word_o[23:22] == cnt;
  endproperty
  a_count: assert property (p_count) else $error("bad count");
  // switch outputs move to the next byte at the trigger, so they are
  // checked as the packet starts, while they still match its byte
  property p_diff;
    pkt_start_o && md == 2'h0 |-> sel_diff_o && !sel_zero_o
      && sel_channel_o == {1'b0, pkt_word_o[19:16]};
  endproperty
  a_diff: assert property (p_diff) else $error("bad diff select");
  property p_zero;
    pkt_start_o && md == 2'h1 |-> sel_zero_o && test_current_o == 32'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("bad zero mode");
  property p_se;
    pkt_start_o && md[1] |-> !sel_diff_o
      && sel_channel_o == {md[0], pkt_word_o[19:16]};
  endproperty
  a_se: assert property (p_se) else $error("bad single select");
  property p_test;
    pkt_start_o |-> test_current_o == 32'h0
      || test_current_o == (32'h1 << sel_channel_o);
  endproperty
  a_test: assert property (p_test) else $error("stray current");
  property p_pkt;
    pkt_start_o |-> adc_start_o ##1 (!pkt_valid_o) [*8] ##[14:40] pkt_valid_o;
  endproperty
  a_pkt: assert property (p_pkt) else $error("packet timing");
  property p_ack;
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer");
  c_se_high: cover property (pkt_valid_o && md == 2'h3);
  c_wrap: cover property (pkt_valid_o && cnt == 2'h3);
  c_test: cover property (test_current_o != 32'h0);
endmodule
bind sample_packet_formatter sample_packet_formatter_props
  sample_packet_formatter_props_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .ack_o, .adc_start_o, .sel_channel_o, .sel_diff_o,
  .sel_zero_o, .test_current_o, .pkt_word_o, .pkt_valid_o, .pkt_start_o);
`default_nettype wire

// ===== adc_model.sv
// converter model answering each start pulse after a fixed conversion
// assumes start is a one-cycle pulse on clk_i
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // start and result
  input  wire logic        start_i,
  input  wire logic [13:0] smp_i,
  output var  logic        done_o,
  output wire logic [13:0] data_o
);
  logic [4:0]  n;
  logic [13:0] v;
  logic        busy;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      done_o <= 1'b0;
      n <= 5'h0;
    end else if (start_i) begin
      v <= smp_i;
      n <= 5'd18;
      busy <= 1'b1;
      done_o <= 1'b0;
    end else if (busy) begin
      if (n == 5'h0) begin
        busy <= 1'b0;
        done_o <= 1'b1;
      end else n <= n - 5'h1;
    end
  end
  // no valid result outside done: show the inverse, not a stale value
  assign data_o = done_o ? v : ~v;
endmodule
`default_nettype wire

// ===== adc_sample_packet_formatter_tb_top.sv
// self-checking bench for the sample packet formatter
// assumes the converter model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module adc_sample_packet_formatter_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic        ext_sample_trigger_i = 1'b0;
  logic        ext_acq_start_i = 1'b0;
  wire  [31:0] dat_o, test_current_o;
  wire         ack_o, adc_start_o, adc_done_i, pkt_valid_o, pkt_start_o;
  wire         sel_diff_o, sel_zero_o;
  wire  [13:0] adc_data_i;
  wire  [4:0]  sel_channel_o;
  wire  [2:0]  test_config_o;
  wire  [24:0] pkt_word_o;
  logic [13:0] smp [0:31];
  logic [31:0] expq [$];
  logic [31:0] q, last;
  logic [7:0]  b;
  logic [4:0]  nstart = 5'h0, pi = 5'h0;
  logic [1:0]  ecnt = 2'h0;
  logic [1:0]  hold = 2'h0;
  integer      seed = 52, num_errors = 0, samples_checked = 0, i, k, w;
  always #50 clk_i = ~clk_i;
  sample_packet_formatter sample_packet_formatter_i (.clk_i, .rst_i,
    .ce_i(1'b1), .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .ext_sample_trigger_i, .ext_acq_start_i, .adc_start_o,
    .adc_done_i, .adc_data_i, .sel_channel_o, .sel_diff_o, .sel_zero_o,
    .test_current_o, .test_config_o, .pkt_word_o, .pkt_valid_o,
    .pkt_start_o);
  adc_model adc_model_i (.clk_i, .rst_i, .start_i(adc_start_o),
    .smp_i(smp[nstart]), .done_o(adc_done_i), .data_o(adc_data_i));
  task chk(input [31:0] seen, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wb(input [3:0] a, input wr, input [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  // note the expected word as the control byte goes in
  task push(input [7:0] cb, input keep);
    wb(4'h8, 1'b1, {24'h0, cb});
    if (keep) begin
      last = {8'h0, ecnt, cb[5:0], {3{smp[pi][13]}}, smp[pi][12:0]};
      expq.push_back(last);
      ecnt = ecnt + 2'h1;
      pi = pi + 5'h1;
    end
  endtask
  task drain;
    w = 0;
    while (expq.size() != 0 && w < 2000) begin
      @(posedge clk_i);
      w = w + 1;
    end
    if (expq.size() != 0) num_errors = num_errors + 1;
  endtask
  // the test config and current outputs are looked at as the packet starts
  task wait_start;
    w = 0;
    while (pkt_start_o !== 1'b1 && w < 2000) begin
      @(posedge clk_i);
      w = w + 1;
    end
    if (w >= 2000) num_errors = num_errors + 1;
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    if (adc_start_o === 1'b1) nstart <= nstart + 5'h1;
    ext_sample_trigger_i <= hold[0] ? 1'b0 : 1'($random(seed));
    ext_acq_start_i <= hold[1] ? 1'b0 : 1'($random(seed));
    if (pkt_valid_o === 1'b1)
      chk({7'h0, pkt_word_o}, expq.pop_front());
  end
  initial begin
    #500000;
    num_errors = num_errors + 1;
    results;
  end
  initial begin
    for (i = 0; i < 32; i = i + 1) smp[i] = 14'($random(seed));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(4'h2, 1'b0, 32'h0);
    chk(q, 32'h0);
    wb(4'h0, 1'b0, 32'h0);
    chk(q, 32'h0);
    // one byte prefetched, sixteen queued, the last one refused
    for (i = 0; i < 18; i = i + 1) push(8'($random(seed)), i < 17);
    wb(4'h4, 1'b0, 32'h0);
    chk({29'h0, q[6:4]}, 32'h7);
    wb(4'h0, 1'b1, 32'h1);
    drain;
    wb(4'hc, 1'b0, 32'h0);
    chk({7'h0, q[24:0]}, last);
    $display("fill and drain done");
    wb(4'h0, 1'b1, 32'h100);
    ecnt = 2'h0;
    push(8'hc5, 1'b1);
    push(8'h3a, 1'b1);
    wb(4'h0, 1'b1, 32'h1);
    drain;
    $display("software reset done");
    for (k = 0; k < 8; k = k + 1) begin
      wb(4'h0, 1'b1, 32'h9 | (32'(k[1:0]) << 4));
      b = {2'h0, k[2] ? 2'h2 : 2'h0, 4'($random(seed))};
      push(b, 1'b1);
      wait_start;
      chk({29'h0, test_config_o}, 32'(k[2:0]));
      chk(test_current_o, 32'h1 << b[3:0]);
      drain;
    end
    $display("test modes done");
    // external sync: start pin gates the run, pin edges trigger
    hold = 2'h3;
    wb(4'h0, 1'b1, 32'h100);
    ecnt = 2'h0;
    wb(4'h0, 1'b1, 32'h3);
    push(8'h47, 1'b1);
    repeat (60) @(posedge clk_i);
    wb(4'h4, 1'b0, 32'h0);
    chk({31'h0, q[7]}, 32'h0);
    hold = 2'h1;
    repeat (60) @(posedge clk_i);
    wb(4'h4, 1'b0, 32'h0);
    chk({31'h0, q[7]}, 32'h1);
    chk(expq.size(), 32'h1);
    hold = 2'h0;
    drain;
    wb(4'h0, 1'b1, 32'h7);
    push(8'hd1, 1'b1);
    drain;
    wb(4'h4, 1'b0, 32'h0);
    chk({31'h0, q[31:16] != 16'h0}, 32'h1);
    $display("external sync done");
    results;
  end
endmodule
`default_nettype wire
